// [logic/amrc_pkg.sv]
// Constants, register map and carrier types of the converter control core.
package amrc_pkg;

    // Clock and timing.
    localparam int CLK_HZ        = 100_000_000;
    localparam int POR_CYCLES    = 216;
    localparam int START_CYCLES  = 512;
    localparam int GAP_NS        = 1000;
    localparam int GAP_CYCLES    = (GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int CNT_W         = 10;
    localparam logic [CNT_W-1:0] POR_LAST   = CNT_W'(POR_CYCLES - 1);
    localparam logic [CNT_W-1:0] START_LAST = CNT_W'(START_CYCLES - 1);
    localparam logic [7:0]       CLKDET_LAST = 8'hFF;

    // Register indices; the byte address is four times the index.
    localparam logic [4:0] IDX_STATUS  = 5'h01;
    localparam logic [4:0] IDX_CFG1    = 5'h03;
    localparam logic [4:0] IDX_CFG3    = 5'h05;
    localparam logic [4:0] IDX_OFS_LO  = 5'h07;
    localparam logic [4:0] IDX_OFS_MID = 5'h08;
    localparam logic [4:0] IDX_OFS_HI  = 5'h09;
    localparam logic [4:0] IDX_GN_LO   = 5'h0A;
    localparam logic [4:0] IDX_GN_MID  = 5'h0B;
    localparam logic [4:0] IDX_GN_HI   = 5'h0C;
    localparam logic [4:0] IDX_CMD     = 5'h0E;
    localparam logic [4:0] IDX_DATA    = 5'h10;

    // Field positions and codes.
    localparam int ST_RESET_BIT  = 0;
    localparam int ST_CLKEXT_BIT = 1;
    localparam int ST_OVR_BIT    = 2;
    localparam int ST_DATA_READY_N_BIT   = 3;
    localparam int CHOP_LSB      = 5;
    localparam int PDOWN_BIT     = 7;
    localparam logic [1:0] CHOP_AC2  = 2'h2;
    localparam logic [1:0] CHOP_AC4  = 2'h3;
    localparam logic [7:0] CMD_RESET = 8'h06;
    localparam logic [3:0] OE_AC2    = 4'h3;
    localparam logic [3:0] OE_AC4    = 4'hF;

    // Reset values and calibration arithmetic.
    localparam logic [7:0]  CFG_RESET  = 8'h00;
    localparam logic [23:0] OFS_RESET  = 24'h000000;
    localparam logic [23:0] GAIN_UNITY = 24'h400000;
    localparam int GAIN_SHIFT = 22;
    localparam int CAL_W      = 51;
    localparam int OVR_PCT    = 106;
    localparam logic signed [CAL_W-1:0] CAL_POS_MAX = 51'sh7FFFFF;
    localparam logic signed [CAL_W-1:0] CAL_NEG_MIN = -51'sh800000;
    localparam logic signed [CAL_W-1:0] CAL_OVR_LIM = (51'sh800000 * OVR_PCT) / 100;

    typedef enum logic [2:0] {
        ST_POR     = 3'h0,
        ST_STARTUP = 3'h1,
        ST_RUN     = 3'h3,
        ST_IDLE    = 3'h2,
        ST_PDOWN   = 3'h6
    } amrc_fsm_type;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [6:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } amrc_wb_req_type;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } amrc_wb_rsp_type;

endpackage

// [logic/amrc_core.sv]
// Control core: excitation drive, clock select, power-down, reset sequencing, calibration.
//
// Overview of operation
// - Excitation polarity follows alternating conversion phases.
// - Reversed phase inverts reference; phases subtracted.
// - Drive A and B never on together.
// - Drives toggle once per conversion only.
// - Mode 10 uses pins 0-1; 11 adds 2-3.
// - Pick external clock if present; report it.
// - Power-down pin low halts conversion; registers kept.
// - Outputs stay driven in both power-downs.
// - Config three bit 7 is software power-down.
// - Any reset reinitialises control and registers.
// - Reset sets sticky status flag, software clears.
// - Start high after reset begins converting.
// - Data-ready held low 216 cycles after power-on.
// - First conversion 512 cycles after data-ready high.
// - Pin or command reset: conversion 512 cycles later.
// - Output is (filter minus offset) times gain.
// - Calibrated result saturates to 24 bits.
// - Offset word: 24-bit two's complement, three bytes.
// - Zero offset leaves data uncorrected.
// - Beyond 106 percent flags overrange.
// - Gain word unsigned, 400000h is unity.
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
module amrc_core
    import amrc_pkg::*;
#(
    parameter int GAP_CYC = GAP_CYCLES
) (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire amrc_wb_req_type wb_req_i,
    output amrc_wb_rsp_type      wb_rsp_o,
    input  wire logic            reset_pin_n_i,
    input  wire logic            power_down_ctl_n_i,
    input  wire logic            start_i,
    input  wire logic            ext_clock_input_i,
    input  wire logic [23:0]     filt_data_i,
    input  wire logic            filt_valid_i,
    output logic                 data_ready_n_o,
    output logic                 conv_run_o,
    output logic                 ref_invert_o,
    output logic                 clk_sel_ext_o,
    output logic                 pdown_o,
    output logic [3:0]           gpio_o,
    output logic [3:0]           gpio_oe_o
);

    // A single-cycle break would not give the switches a full idle cycle on each side.
    if (GAP_CYC < 2 || GAP_CYC > 255) begin : g_chk
        $error("GAP_CYC must lie in 2..255");
    end

    typedef struct packed {
        amrc_fsm_type    fsm;
        logic [CNT_W-1:0] cnt;
        logic            rpin_s1;
        logic            rpin_s2;
        logic            pdpin_s1;
        logic            pdpin_s2;
        logic            start_s1;
        logic            start_s2;
        logic            ck_s1;
        logic            ck_s2;
        logic            ck_s3;
        logic [7:0]      win;
        logic            edge_seen;
        logic            clk_ext;
        logic            reset_flag;
        logic            ovr;
        logic [7:0]      cfg1;
        logic [7:0]      cfg3;
        logic [23:0]     ofs;
        logic [23:0]     gain;
        logic [23:0]     data;
        logic [23:0]     prev;
        logic            first;
        logic            phase;
        logic [7:0]      gap;
        logic            exc_a;
        logic            exc_b;
        logic [3:0]      gpio_oe;
        logic            ref_inv;
        logic            conv_run;
        logic            data_ready_n_n;
        logic            pdown;
        amrc_wb_rsp_type rsp;
    } amrc_core_state_type;

    localparam amrc_core_state_type RESET_STATE = '{
        fsm: ST_POR, cnt: '0, rpin_s1: 1'b1, rpin_s2: 1'b1, pdpin_s1: 1'b1, pdpin_s2: 1'b1,
        start_s1: 1'b0, start_s2: 1'b0, ck_s1: 1'b0, ck_s2: 1'b0, ck_s3: 1'b0, win: '0,
        edge_seen: 1'b0, clk_ext: 1'b0, reset_flag: 1'b1, ovr: 1'b0, cfg1: CFG_RESET,
        cfg3: CFG_RESET, ofs: OFS_RESET, gain: GAIN_UNITY, data: '0, prev: '0,
        first: 1'b1, phase: 1'b0, gap: '0, exc_a: 1'b0, exc_b: 1'b0, gpio_oe: '0,
        ref_inv: 1'b0, conv_run: 1'b0, data_ready_n_n: 1'b0, pdown: 1'b0, rsp: '0};

    localparam logic [7:0] GAP_LOAD = 8'(GAP_CYC);

    amrc_core_state_type s;
    amrc_core_state_type next_s;

    // Chop-style pairing: the current phase sign decides the subtraction order.
    function automatic logic signed [24:0] half_diff(input logic [23:0] cur,
                                                     input logic [23:0] prv,
                                                     input logic        rev);
        logic signed [24:0] d;
        d = rev ? ($signed({prv[23], prv}) - $signed({cur[23], cur}))
                : ($signed({cur[23], cur}) - $signed({prv[23], prv}));
        return d >>> 1;
    endfunction

    // Returns {overrange, saturated result}.
    function automatic logic [24:0] calibrate(input logic signed [24:0] x,
                                              input logic [23:0]        ofs,
                                              input logic [23:0]        gain);
        logic signed [25:0]      diff;
        logic signed [CAL_W-1:0] prod;
        logic signed [CAL_W-1:0] scaled;
        logic                    ovr;
        logic [23:0]             res;
        diff   = $signed({x[24], x}) - $signed({{2{ofs[23]}}, ofs});
        prod   = diff * $signed({1'b0, gain});
        scaled = prod >>> GAIN_SHIFT;
        ovr    = (scaled > CAL_OVR_LIM) || (scaled < -CAL_OVR_LIM);
        if (scaled > CAL_POS_MAX) begin
            res = CAL_POS_MAX[23:0];
        end else if (scaled < CAL_NEG_MIN) begin
            res = CAL_NEG_MIN[23:0];
        end else begin
            res = scaled[23:0];
        end
        return {ovr, res};
    endfunction

    always_comb begin
        logic [4:0]         idx;
        logic               req;
        logic               wr;
        logic               rd_data;
        logic               cmd_rst;
        logic               soft_rst;
        logic               pd_any;
        logic               ac_mode;
        logic               publish;
        logic signed [24:0] comb;
        logic [24:0]        cal;
        idx      = wb_req_i.adr[6:2];
        req      = wb_req_i.cyc && wb_req_i.stb;
        wr       = req && wb_req_i.we && s.rsp.ack && wb_req_i.sel[0] && s.pdpin_s2;
        rd_data  = req && !wb_req_i.we && s.rsp.ack && idx == IDX_DATA;
        cmd_rst  = wr && idx == IDX_CMD && wb_req_i.dat[7:0] == CMD_RESET;
        soft_rst = !s.rpin_s2 || cmd_rst;
        pd_any   = !s.pdpin_s2 || s.cfg3[PDOWN_BIT];
        ac_mode  = s.cfg1[CHOP_LSB+1];
        publish  = 1'b0;
        comb     = '0;
        cal      = '0;
        next_s   = s;

        next_s.rpin_s1  = reset_pin_n_i;
        next_s.rpin_s2  = s.rpin_s1;
        next_s.pdpin_s1 = power_down_ctl_n_i;
        next_s.pdpin_s2 = s.pdpin_s1;
        next_s.start_s1 = start_i;
        next_s.start_s2 = s.start_s1;
        next_s.ck_s1    = ext_clock_input_i;
        next_s.ck_s2    = s.ck_s1;
        next_s.ck_s3    = s.ck_s2;

        // An external clock counts as present when it toggled within the last window.
        next_s.win = s.win + 8'h01;
        if (s.ck_s2 != s.ck_s3) begin
            next_s.edge_seen = 1'b1;
        end
        if (s.win == CLKDET_LAST) begin
            next_s.clk_ext   = s.edge_seen || (s.ck_s2 != s.ck_s3);
            next_s.edge_seen = 1'b0;
        end

        // Classic Wishbone: ack one cycle after the request; reads latch at that edge, writes act at the edge ending the ack cycle.
        next_s.rsp.ack = req && !s.rsp.ack;
        if (req && !s.rsp.ack) begin
            case (idx)
                IDX_STATUS: begin
                    next_s.rsp.dat = '0;
                    next_s.rsp.dat[ST_RESET_BIT]  = s.reset_flag;
                    next_s.rsp.dat[ST_CLKEXT_BIT] = s.clk_ext;
                    next_s.rsp.dat[ST_OVR_BIT]    = s.ovr;
                    next_s.rsp.dat[ST_DATA_READY_N_BIT]   = s.data_ready_n_n;
                end
                IDX_CFG1:    next_s.rsp.dat = {24'h000000, s.cfg1};
                IDX_CFG3:    next_s.rsp.dat = {24'h000000, s.cfg3};
                IDX_OFS_LO:  next_s.rsp.dat = {24'h000000, s.ofs[7:0]};
                IDX_OFS_MID: next_s.rsp.dat = {24'h000000, s.ofs[15:8]};
                IDX_OFS_HI:  next_s.rsp.dat = {24'h000000, s.ofs[23:16]};
                IDX_GN_LO:   next_s.rsp.dat = {24'h000000, s.gain[7:0]};
                IDX_GN_MID:  next_s.rsp.dat = {24'h000000, s.gain[15:8]};
                IDX_GN_HI:   next_s.rsp.dat = {24'h000000, s.gain[23:16]};
                IDX_DATA:    next_s.rsp.dat = {8'h00, s.data};
                default:     next_s.rsp.dat = '0;
            endcase
        end
        if (wr) begin
            case (idx)
                IDX_STATUS: begin
                    if (wb_req_i.dat[ST_RESET_BIT]) begin
                        next_s.reset_flag = 1'b0;
                    end
                end
                IDX_CFG1:    next_s.cfg1 = wb_req_i.dat[7:0];
                IDX_CFG3:    next_s.cfg3 = wb_req_i.dat[7:0];
                IDX_OFS_LO:  next_s.ofs[7:0]    = wb_req_i.dat[7:0];
                IDX_OFS_MID: next_s.ofs[15:8]   = wb_req_i.dat[7:0];
                IDX_OFS_HI:  next_s.ofs[23:16]  = wb_req_i.dat[7:0];
                IDX_GN_LO:   next_s.gain[7:0]   = wb_req_i.dat[7:0];
                IDX_GN_MID:  next_s.gain[15:8]  = wb_req_i.dat[7:0];
                IDX_GN_HI:   next_s.gain[23:16] = wb_req_i.dat[7:0];
                default:     next_s.cnt = next_s.cnt;
            endcase
        end
        if (rd_data) begin
            next_s.data_ready_n_n = 1'b1;
        end

        case (s.fsm)
            ST_POR: begin
                next_s.data_ready_n_n = 1'b0;
                next_s.cnt    = s.cnt + 1'b1;
                if (s.cnt == POR_LAST) begin
                    next_s.fsm    = ST_STARTUP;
                    next_s.cnt    = '0;
                    next_s.data_ready_n_n = 1'b1;
                end
            end
            ST_STARTUP: begin
                next_s.cnt = s.cnt + 1'b1;
                if (pd_any) begin
                    next_s.fsm = ST_PDOWN;
                end else if (s.cnt == START_LAST) begin
                    next_s.cnt = '0;
                    next_s.fsm = s.start_s2 ? ST_RUN : ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (pd_any) begin
                    next_s.fsm = ST_PDOWN;
                end else if (s.start_s2) begin
                    next_s.fsm = ST_RUN;
                end
            end
            ST_RUN: begin
                if (pd_any) begin
                    next_s.fsm = ST_PDOWN;
                end else if (!s.start_s2) begin
                    next_s.fsm = ST_IDLE;
                end else if (filt_valid_i) begin
                    if (ac_mode) begin
                        next_s.phase   = !s.phase;
                        next_s.ref_inv = !s.phase;
                        next_s.exc_a   = 1'b0;
                        next_s.exc_b   = 1'b0;
                        next_s.gap     = GAP_LOAD;
                        next_s.prev    = filt_data_i;
                        next_s.first   = 1'b0;
                        publish        = !s.first;
                        comb           = half_diff(filt_data_i, s.prev, s.phase);
                    end else begin
                        publish = 1'b1;
                        comb    = $signed({filt_data_i[23], filt_data_i});
                    end
                end
            end
            ST_PDOWN: begin
                if (!pd_any) begin
                    next_s.fsm = ST_STARTUP;
                    next_s.cnt = '0;
                end
            end
            default: next_s.fsm = ST_POR;
        endcase

        if (publish) begin
            cal           = calibrate(comb, s.ofs, s.gain);
            next_s.data   = cal[23:0];
            next_s.ovr    = cal[24];
            next_s.data_ready_n_n = 1'b0;
        end

        // The new polarity is applied only after the break gap has run out.
        if (s.gap != 8'h00 && next_s.gap == s.gap) begin
            next_s.gap = s.gap - 8'h01;
            if (s.gap == 8'h01) begin
                next_s.exc_a = !s.phase;
                next_s.exc_b = s.phase;
            end
        end

        if (next_s.fsm == ST_RUN && s.fsm != ST_RUN) begin
            next_s.phase   = 1'b0;
            next_s.ref_inv = 1'b0;
            next_s.first   = 1'b1;
            next_s.gap     = ac_mode ? GAP_LOAD : 8'h00;
        end
        if (next_s.fsm != ST_RUN || !ac_mode) begin
            next_s.exc_a   = 1'b0;
            next_s.exc_b   = 1'b0;
            next_s.gap     = 8'h00;
            next_s.ref_inv = 1'b0;
        end
        next_s.conv_run = next_s.fsm == ST_RUN;

        // Pins stay actively driven in power-down; only the drive level is parked.
        case (s.cfg1[CHOP_LSB+1:CHOP_LSB])
            CHOP_AC2: next_s.gpio_oe = OE_AC2;
            CHOP_AC4: next_s.gpio_oe = OE_AC4;
            default:  next_s.gpio_oe = 4'h0;
        endcase

        // Reset wins over everything, but the synchronisers, clock detector and bus response keep running.
        if (soft_rst) begin
            next_s.fsm        = ST_STARTUP;
            next_s.cnt        = '0;
            next_s.reset_flag = 1'b1;
            next_s.ovr        = 1'b0;
            next_s.cfg1       = CFG_RESET;
            next_s.cfg3       = CFG_RESET;
            next_s.ofs        = OFS_RESET;
            next_s.gain       = GAIN_UNITY;
            next_s.data       = '0;
            next_s.prev       = '0;
            next_s.first      = 1'b1;
            next_s.phase      = 1'b0;
            next_s.gap        = 8'h00;
            next_s.exc_a      = 1'b0;
            next_s.exc_b      = 1'b0;
            next_s.gpio_oe    = 4'h0;
            next_s.ref_inv    = 1'b0;
            next_s.conv_run   = 1'b0;
            next_s.data_ready_n_n     = 1'b1;
        end
        next_s.pdown = next_s.fsm == ST_PDOWN;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign wb_rsp_o       = s.rsp;
    assign data_ready_n_o = s.data_ready_n_n;
    assign conv_run_o     = s.conv_run;
    assign ref_invert_o   = s.ref_inv;
    assign clk_sel_ext_o  = s.clk_ext;
    assign pdown_o        = s.pdown;
    assign gpio_o         = {s.exc_b, s.exc_a, s.exc_b, s.exc_a};
    assign gpio_oe_o      = s.gpio_oe;

    // Cycles since power-on release, saturating; read only by the checks below.
    logic [CNT_W-1:0] por_age;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            por_age <= '0;
        end else if (por_age != '1) begin
            por_age <= por_age + 1'b1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_break;
        !s.exc_a && !s.exc_b;
    endsequence

    property p_no_overlap;
        !(s.exc_a && s.exc_b);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("drives overlap");

    property p_gap;
        $fell(s.exc_a) || $fell(s.exc_b) |-> s_break ##1 s_break;
    endproperty
    a_gap: assert property (p_gap) else $error("no break gap at reversal");

    property p_toggle;
        $changed(s.phase) && s.fsm == ST_RUN && $past(s.fsm) == ST_RUN
            |-> $past(filt_valid_i);
    endproperty
    a_toggle: assert property (p_toggle) else $error("phase moved without conversion");

    property p_por_low;
        por_age < CNT_W'(POR_CYCLES) |-> !data_ready_n_o;
    endproperty
    a_por_low: assert property (p_por_low) else $error("data ready rose early");

    property p_por_high;
        por_age == CNT_W'(POR_CYCLES) && s.rpin_s2 |-> data_ready_n_o && s.fsm == ST_STARTUP;
    endproperty
    a_por_high: assert property (p_por_high) else $error("data ready late");

    property p_startup;
        s.fsm == ST_STARTUP && s.cnt == START_LAST && s.start_s2 && !pdown_o
            && s.pdpin_s2 && !s.cfg3[PDOWN_BIT] && s.rpin_s2 |=> conv_run_o;
    endproperty
    a_startup: assert property (p_startup) else $error("conversion not started");

    property p_no_early;
        s.fsm == ST_STARTUP |-> !conv_run_o;
    endproperty
    a_no_early: assert property (p_no_early) else $error("conversion before delay");

    property p_pdown;
        !s.pdpin_s2 || s.cfg3[PDOWN_BIT] |=> !conv_run_o ##1 !conv_run_o;
    endproperty
    a_pdown: assert property (p_pdown) else $error("runs in power-down");

    property p_oe4;
        s.cfg1[CHOP_LSB+1:CHOP_LSB] == CHOP_AC4 && $stable(s.cfg1) |-> gpio_oe_o == OE_AC4;
    endproperty
    a_oe4: assert property (p_oe4) else $error("four-wire pins not driven");

    property p_flag;
        !s.rpin_s2 |=> s.reset_flag && s.cfg1 == CFG_RESET && s.gain == GAIN_UNITY;
    endproperty
    a_flag: assert property (p_flag) else $error("reset did not reinitialise");

    property p_cal;
        s.fsm == ST_RUN && filt_valid_i && !s.cfg1[CHOP_LSB+1] && s.start_s2
            && s.pdpin_s2 && !s.cfg3[PDOWN_BIT] && s.rpin_s2 && s.ofs == OFS_RESET
            && s.gain == GAIN_UNITY && !(wb_req_i.cyc && wb_req_i.stb && s.rsp.ack)
            |=> s.data == $past(filt_data_i) && !data_ready_n_o;
    endproperty
    a_cal: assert property (p_cal) else $error("unity calibration altered data");

endmodule // amrc_core

// [tb/amrc_filter_model.sv]
// Far-side model: filter result source and external clock source.
`timescale 1ns/1ps
module amrc_filter_model (
    input  wire logic        clk_i,
    input  wire logic [23:0] sample_i,
    input  wire logic        ext_en_i,
    output logic [23:0]      filt_data_o,
    output logic             filt_valid_o,
    output logic             ext_clk_o
);
    logic [5:0] div;

    initial begin
        div          = 6'h00;
        filt_valid_o = 1'b0;
        filt_data_o  = 24'h000000;
        ext_clk_o    = 1'b0;
    end

    // Off the valid cycle the bus carries inverted bits, so a stale capture cannot match.
    always @(posedge clk_i) begin
        div          <= div + 6'h01;
        filt_valid_o <= (div == 6'h3F);
        filt_data_o  <= (div == 6'h3F) ? sample_i : ~sample_i;
        ext_clk_o    <= ext_en_i & div[3];
    end
endmodule // amrc_filter_model

// [tb/amrc_core_test.sv]
// Self-checking bench for the converter control core.
`timescale 1ns/1ps
module amrc_core_test;
    import amrc_pkg::*;
    logic            clk_i = 1'b0;
    logic            rst_i = 1'b1;
    logic            pin_n = 1'b1;
    logic            pwr_n = 1'b1;
    logic            ext_en = 1'b0;
    logic            start = 1'b1;
    logic            a_prev = 1'b0;
    logic [23:0]     sample = 24'h000000;
    amrc_wb_req_type req = '0;
    amrc_wb_rsp_type rsp;
    logic [23:0]     fdata, exp;
    logic            fvalid, eclk, data_ready_n_n, run, rinv, csel, pdn, ovr;
    logic [3:0]      gp, gp_oe;
    logic [31:0]     rd;
    int              error_cnt = 0, total_checks = 0, cycles = 0, n;
    int              bad = 0, a_rise = 0, v_cnt = 0;
    logic [23:0]     cx [7] = '{24'h234567, 24'h000000, 24'h123456, 24'h000000,
                                24'h500000, 24'hB00000, 24'h800000};
    logic [23:0]     co [7] = '{24'h000000, 24'h000001, 24'h000000, 24'hFFFFFF,
                                24'h000000, 24'h000000, 24'h7FFFFF};
    logic [23:0]     cg [7] = '{24'h400000, 24'h400000, 24'h3CCCCC, 24'h400000,
                                24'h800000, 24'h800000, 24'h400000};
    logic [1:0]      md [3] = '{2'h0, CHOP_AC2, CHOP_AC4};
    logic [3:0]      oe [3] = '{4'h0, OE_AC2, OE_AC4};

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    amrc_core #(.GAP_CYC(4)) u_amrc_core (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
        .wb_rsp_o(rsp), .reset_pin_n_i(pin_n), .power_down_ctl_n_i(pwr_n), .start_i(start),
        .ext_clock_input_i(eclk), .filt_data_i(fdata), .filt_valid_i(fvalid),
        .data_ready_n_o(data_ready_n_n), .conv_run_o(run), .ref_invert_o(rinv), .clk_sel_ext_o(csel),
        .pdown_o(pdn), .gpio_o(gp), .gpio_oe_o(gp_oe));

    amrc_filter_model u_amrc_filter_model (.clk_i(clk_i), .sample_i(sample), .ext_en_i(ext_en),
        .filt_data_o(fdata), .filt_valid_o(fvalid), .ext_clk_o(eclk));

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic bus(input logic we, input logic [4:0] idx, input logic [7:0] wd);
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'hF, dat: {24'h0, wd}};
        do @(posedge clk_i); while (rsp.ack !== 1'b1);
        rd = rsp.dat;
        req <= '0;
    endtask

    task automatic wait_rdy();
        repeat (2) @(posedge clk_i);
        while (data_ready_n_n !== 1'b0) @(posedge clk_i);
    endtask

    task automatic count_run();
        n = 0;
        do begin @(posedge clk_i); #1; n++; end while (run !== 1'b1 || n < 3);
    endtask

    function automatic logic [23:0] cal(input logic [23:0] x, o, g, output logic ov);
        logic signed [50:0] s;
        s = ((51'(signed'(x)) - 51'(signed'(o))) * $signed({27'h0, g})) >>> 22;
        ov = (s > CAL_OVR_LIM) || (s < -CAL_OVR_LIM);
        return (s > 51'sh7FFFFF) ? 24'h7FFFFF : (s < -51'sh800000) ? 24'h800000 : s[23:0];
    endfunction

    // Flags overlap of the two drives or a drive that disagrees with the reference phase.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (!rst_i) begin
            bad    <= bad + int'((gp[0] & gp[1]) | (gp[0] & rinv) | (gp[1] & ~rinv));
            a_rise <= a_rise + int'(gp[0] && !a_prev && gp_oe == 4'hF);
            a_prev <= gp[0];
            v_cnt  <= v_cnt + int'(fvalid && run && gp_oe == 4'hF);
        end
        if (cycles == 20000) begin
            error_cnt = error_cnt + 1;
            complete_run();
        end
    end

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        n = 0;
        do begin @(posedge clk_i); #1; n++; end while (data_ready_n_n !== 1'b1);
        chk("por_wait", n, 216);
        count_run();
        chk("start_delay", 32'(n >= 509 && n <= 515), 1);
        bus(0, IDX_STATUS, 0);
        chk("reset_flag", rd[ST_RESET_BIT], 1);
        chk("clk_internal", rd[ST_CLKEXT_BIT], 0);
        bus(0, 5'h1F, 0);
        chk("unmapped", rd, 0);
        for (int s = 0; s < 2; s++) begin
            bus(1, IDX_STATUS, 8'h01);
            bus(1, IDX_OFS_LO, 8'h5A);
            bus(0, IDX_STATUS, 0);
            chk("flag_clear", rd[ST_RESET_BIT], 0);
            // The bus is left idle before the command so the interface is fresh.
            if (s == 0) bus(1, IDX_CMD, CMD_RESET);
            else begin
                @(posedge clk_i) pin_n <= 1'b0;
                repeat (4) @(posedge clk_i);
                pin_n <= 1'b1;
            end
            count_run();
            chk("restart", 32'(n >= 510 && n <= 520), 1);
            bus(0, IDX_STATUS, 0);
            chk("flag_set", rd[ST_RESET_BIT], 1);
            bus(0, IDX_OFS_LO, 0);
            chk("ofs_reset", rd[7:0], 0);
        end
        for (int c = 0; c < 7; c++) begin
            sample <= cx[c];
            for (int b = 0; b < 3; b++) bus(1, IDX_OFS_LO + 5'(b), co[c][8*b +: 8]);
            for (int b = 0; b < 3; b++) bus(1, IDX_GN_LO + 5'(b), cg[c][8*b +: 8]);
            repeat (2) begin wait_rdy(); bus(0, IDX_DATA, 0); end
            exp = cal(cx[c], co[c], cg[c], ovr);
            chk("cal_data", rd[23:0], exp);
            bus(0, IDX_STATUS, 0);
            chk("overrange", rd[ST_OVR_BIT], ovr);
        end
        for (int m = 0; m < 3; m++) begin
            bus(1, IDX_CFG1, {1'b0, md[m], 5'h00});
            repeat (3) @(posedge clk_i);
            chk("drive_enable", gp_oe, oe[m]);
        end
        repeat (640) @(posedge clk_i);
        chk("four_wire", gp[3:2], gp[1:0]);
        chk("drive_rate", 32'(a_rise * 2 <= v_cnt + 2 && a_rise >= 3), 1);
        chk("no_overlap", bad, 0);
        bus(1, IDX_CFG3, 8'h80);
        repeat (3) @(posedge clk_i);
        chk("sw_pdown", pdn, 1);
        chk("oe_held_sw", gp_oe, OE_AC4);
        bus(1, IDX_CFG3, 8'h00);
        @(posedge clk_i) pwr_n <= 1'b0;
        start <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("hw_pdown", pdn, 1);
        chk("oe_held_hw", gp_oe, OE_AC4);
        pwr_n <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk("wake", pdn, 0);
        bus(0, IDX_OFS_HI, 0);
        chk("regs_kept", rd[7:0], co[6][23:16]);
        ext_en <= 1'b1;
        repeat (600) @(posedge clk_i);
        chk("clk_ext", csel, 1);
        bus(0, IDX_STATUS, 0);
        chk("clk_ext_bit", rd[ST_CLKEXT_BIT], 1);
        chk("idle_no_start", run, 0);
        start <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk("start_run", run, 1);
        complete_run();
    end
endmodule // amrc_core_test
